// file: hdl/ald_diag.sv
/*
  ald_diag: status latches, ac-load counting, clip routing and output
  mode selection of a four-channel amplifier.
  Assumes control bytes arrive already decoded from the serial interface,
  analog comparators are synchronous to clk, and status_read_done pulses
  once after all five status bytes went out in one transfer.
*/
`timescale 1ns/10ps
`default_nettype none
module ald_diag #(
  parameter int NCH = ald_pkg::NUM_CH
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // decoded control fields (zero after reset upstream as well)
  input  wire logic                 ac_enable_wr,     // write of control_byte_1 ac enable = 1
  input  wire logic                 ac_view_sel,      // control_byte_4 view select
  input  wire logic                 high_current,     // control_byte_4 current mode
  input  wire logic                 line_driver_sel,  // control_byte_4 mode bit
  input  wire logic                 gain_front_16,    // control_byte_3 front pair 16 dB
  input  wire logic                 gain_rear_16,     // control_byte_3 rear pair 16 dB
  input  wire logic [1:0]           clip_thresh,      // clip level code
  input  wire logic [1:0]           clip_lv_mode,     // low voltage clip extension
  input  wire logic [NCH-1:0]       clip_to_stb,      // 1 routes clip to standby pin
  input  wire logic                 temp_on_fault,    // show temperature on fault pin
  input  wire logic                 load_on_fault,    // show load faults on fault pin
  // start-up diagnostics engine
  input  wire logic                 diag_start,       // diagnostics cycle begins
  input  wire logic                 diag_done,        // diagnostics cycle completes
  input  wire logic [2*NCH-1:0]     diag_result,      // measured dc load codes
  input  wire logic                 engine_start,     // measurement disturbed
  input  wire logic                 amp_started,      // amplifier start-up finished
  // supply monitors and analog
  input  wire logic                 sup_above_10v,
  input  wire logic                 sup_above_7v5,
  input  wire logic                 sup_above_6v,
  input  wire logic                 temp_warn,
  input  wire ald_pkg::ald_ana_t [NCH-1:0] ana,
  input  wire logic                 status_read_done, // full five-byte read finished
  // outputs
  output logic [8*NCH-1:0]          channel_status_byte,
  output logic [7:0]                global_status_byte,
  output logic                      fault_pin,        // active high indication
  output logic                      standby_mode_pin, // active high clip indication
  output logic                      cm_reduced,       // 1 selects 0.23 of supply
  output logic [1:0]                gain_16db         // {rear, front} low gain
);

  // whole module state in one struct
  typedef struct packed {
    ald_pkg::ald_ch_t [NCH-1:0] ch;
    logic                       busy;
    logic                       ac_run;
    logic [8*NCH-1:0]           csb;
    logic [7:0]                 gsb;
    logic                       fault;
    logic                       stb;
    logic                       cmr;
    logic [1:0]                 gain;
  } ald_state_t;

  ald_state_t st;       // registered state
  ald_state_t next_st;  // next state

  logic [NCH-1:0] clip_now;  // qualified clip per channel
  logic           clip_ok;   // supply allows clip indication

  // clip qualification: supply gate and threshold pick
  always_comb begin
    unique case (clip_lv_mode)
      ald_pkg::LV_7V5: clip_ok = sup_above_7v5;
      ald_pkg::LV_6V:  clip_ok = sup_above_6v;
      default:         clip_ok = sup_above_10v;
    endcase
    for (int i = 0; i < NCH; i++) begin
      unique case (clip_thresh)
        ald_pkg::CLIP_5PCT:  clip_now[i] = ana[i].clip_lvl[1] & clip_ok;
        ald_pkg::CLIP_10PCT: clip_now[i] = ana[i].clip_lvl[2] & clip_ok;
        default:             clip_now[i] = ana[i].clip_lvl[0] & clip_ok;
      endcase
    end
  end

  // next-state logic for all latches and indicator pins
  always_comb begin
    logic fault_any;
    logic stb_any;
    fault_any = temp_warn & temp_on_fault;
    stb_any = 1'b0;
    next_st = st;
    // busy flag follows the diagnostics engine; done wins over restart
    if (diag_start) begin
      next_st.busy = 1'b1;
    end
    if (diag_done) begin
      next_st.busy = 1'b0;
    end
    // ac measurement runs from the enable write; needs finished start-up
    if (ac_enable_wr) begin
      next_st.ac_run = 1'b1;
    end
    for (int i = 0; i < NCH; i++) begin
      // dc load code: only start and completion may move it
      if (diag_start) begin
        next_st.ch[i].dcl = ald_pkg::DCL_INVALID;
      end else if (diag_done) begin
        // a disturbed measurement cannot be trusted
        next_st.ch[i].dcl = engine_start ? ald_pkg::DCL_INVALID
                                         : diag_result[2*i +: 2];
      end
      // short flags: read clears, live fault sets again (set wins)
      if (status_read_done) begin
        next_st.ch[i].short_load = 1'b0;
        next_st.ch[i].short_sup = 1'b0;
        next_st.ch[i].short_gnd = 1'b0;
      end
      if (ana[i].short_load) next_st.ch[i].short_load = 1'b1;
      if (ana[i].short_sup) next_st.ch[i].short_sup = 1'b1;
      if (ana[i].short_gnd) next_st.ch[i].short_gnd = 1'b1;
      // offset latch: read arms; inside window clears until next read
      if (status_read_done) begin
        next_st.ch[i].offset = 1'b1;
      end else if (ana[i].offset_in) begin
        next_st.ch[i].offset = 1'b0;
      end
      // crossing counter of peak_hit pulses; high_current is not used in this module
      if (ac_enable_wr) begin
        next_st.ch[i].hits = '0;
        next_st.ch[i].ac_load = 1'b0;
      end else if (st.ac_run && amp_started && ana[i].peak_hit
                   && !st.ch[i].ac_load) begin
        if (st.ch[i].hits == ald_pkg::CNT_W'(ald_pkg::PEAK_HITS - 1)) begin
          next_st.ch[i].ac_load = 1'b1;
        end
        next_st.ch[i].hits = st.ch[i].hits + 1'b1;
      end
      // status byte view: dc code or ac bit, the hidden one keeps its value
      next_st.csb[8*i +: 8] = 8'h00;
      if (ac_view_sel) begin
        next_st.csb[8*i + ald_pkg::SB_DCL_LO] = st.ch[i].ac_load;
      end else begin
        next_st.csb[8*i + ald_pkg::SB_DCL_LO +: 2] = st.ch[i].dcl;
      end
      next_st.csb[8*i + ald_pkg::SB_SHORT_LOAD] = st.ch[i].short_load;
      next_st.csb[8*i + ald_pkg::SB_OFFSET] = st.ch[i].offset;
      next_st.csb[8*i + ald_pkg::SB_SHORT_SUP] = st.ch[i].short_sup;
      next_st.csb[8*i + ald_pkg::SB_SHORT_GND] = st.ch[i].short_gnd;
      // pins show live conditions, independent of latches
      if (load_on_fault && (ana[i].short_load | ana[i].short_sup | ana[i].short_gnd)) begin
        fault_any = 1'b1;
      end
      if (clip_to_stb[i]) begin
        stb_any = stb_any | clip_now[i];
      end else begin
        fault_any = fault_any | clip_now[i];
      end
    end
    next_st.gsb = 8'h00;
    next_st.gsb[ald_pkg::GB_DIAG_BUSY] = st.busy;
    next_st.fault = fault_any;
    next_st.stb = stb_any;
    next_st.gain = {gain_rear_16, gain_front_16};
    next_st.cmr = gain_front_16 & gain_rear_16 & line_driver_sel;
  end

  // state register; reset zeroes counters, latches and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      next_st_reset_guard: begin
        st <= '0;
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign channel_status_byte = st.csb;
  assign global_status_byte = st.gsb;
  assign fault_pin = st.fault;
  assign standby_mode_pin = st.stb;
  assign cm_reduced = st.cmr;
  assign gain_16db = st.gain;

endmodule
`default_nettype wire

// file: hdl/ald_pkg.sv
/*
  ald_pkg: shared constants and carriers for the amplifier load and clip
  diagnostics block. Assumes one 20 MHz clock and four amplifier channels.
*/
package ald_pkg;
  localparam int NUM_CH = 4;            // amplifier channels
  localparam int PEAK_HITS = 4;         // comparator firings that prove an ac load
  localparam int CNT_W = 3;             // crossing counter width
  // dc load encodings
  localparam logic [1:0] DCL_NORMAL = 2'h0;
  localparam logic [1:0] DCL_LINEDRV = 2'h1;
  localparam logic [1:0] DCL_OPEN = 2'h2;
  localparam logic [1:0] DCL_INVALID = 2'h3;
  // clip threshold codes
  localparam logic [1:0] CLIP_2PCT = 2'h0;
  localparam logic [1:0] CLIP_5PCT = 2'h1;
  localparam logic [1:0] CLIP_10PCT = 2'h2;
  // low-voltage clip extension codes
  localparam logic [1:0] LV_10V = 2'h0;   // blocked below 10 V
  localparam logic [1:0] LV_7V5 = 2'h1;   // run down to 7.5 V
  localparam logic [1:0] LV_6V = 2'h2;    // run down to 6 V
  // channel status byte field positions
  localparam int SB_DCL_HI = 5;
  localparam int SB_DCL_LO = 4;
  localparam int SB_SHORT_LOAD = 3;
  localparam int SB_OFFSET = 2;
  localparam int SB_SHORT_SUP = 1;
  localparam int SB_SHORT_GND = 0;
  localparam int GB_DIAG_BUSY = 5;      // global status byte busy bit

  // per-channel analog indications
  typedef struct packed {
    logic       short_load;   // shorted load comparator
    logic       short_sup;    // short to supply comparator
    logic       short_gnd;    // short to ground comparator
    logic       offset_in;    // output inside the offset window
    logic       peak_hit;     // peak current comparator pulse
    logic [2:0] clip_lvl;     // distortion above 2/5/10 percent
  } ald_ana_t;

  // per-channel latched state
  typedef struct packed {
    logic [1:0]       dcl;
    logic             short_load;
    logic             short_sup;
    logic             short_gnd;
    logic             offset;
    logic             ac_load;
    logic [CNT_W-1:0] hits;
  } ald_ch_t;
endpackage

// file: dv/ald_checker.sv
/* ald_checker: status latch timing of ald_diag, channel 0 standing for all.
   assumes one clock and the synchronous reset; bound to ald_diag below. */
`timescale 1ns/10ps
`default_nettype none
module ald_checker #(parameter int NCH = ald_pkg::NUM_CH) (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        diag_start,
  input wire logic                        diag_done,
  input wire logic [2*NCH-1:0]            diag_result,
  input wire logic                        engine_start,
  input wire logic                        ac_view_sel,
  input wire logic                        status_read_done,
  input wire ald_pkg::ald_ana_t [NCH-1:0] ana,
  input wire logic [8*NCH-1:0]            channel_status_byte,
  input wire logic [7:0]                  global_status_byte
);
  // status lags its cause by two edges
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  dc_code_a: assert property (
    diag_done && !engine_start && !ac_view_sel ##1 !ac_view_sel && !diag_start && !diag_done
    |=> channel_status_byte[5:4] == $past(diag_result[1:0], 2)) else $error("dc code");
  engine_code_a: assert property (
    diag_done && engine_start && !ac_view_sel ##1 !ac_view_sel && !diag_start && !diag_done
    |=> channel_status_byte[5:4] == 2'h3) else $error("engine code");
  busy_set_a: assert property (diag_start && !diag_done |=> ##1 global_status_byte[5])
    else $error("busy not raised");
  busy_clr_a: assert property (diag_done |=> ##1 !global_status_byte[5])
    else $error("busy not dropped");
  short_set_a: assert property (ana[0].short_load |=> ##1 channel_status_byte[3])
    else $error("short not shown");
  short_clr_a: assert property (
    status_read_done && !ana[0].short_load |=> ##1 !channel_status_byte[3]) else $error("short");
  offset_arm_a: assert property (status_read_done |=> ##1 channel_status_byte[2])
    else $error("offset not armed");
  offset_clr_a: assert property (
    ana[0].offset_in && !status_read_done |=> ##1 !channel_status_byte[2]) else $error("offset");
endmodule
bind ald_diag ald_checker #(.NCH(NCH)) u_chk (.clk, .sys_rst, .diag_start, .diag_done,
  .diag_result, .engine_start, .ac_view_sel, .status_read_done, .ana,
  .channel_status_byte, .global_status_byte);
`default_nettype wire

// file: dv/ald_host_model.sv
/* ald_host_model: bus master ending a status transfer of n bytes.
   assumes one byte per clock; only a five-byte transfer strobes done. */
`timescale 1ns/10ps
`default_nettype none
module ald_host_model (
  input  wire logic       clk,
  input  wire logic       read_go,
  input  wire logic [2:0] n_bytes,
  output var logic        read_done = 1'b0
);
  logic [2:0] left = 3'h0; // bytes still to clock out
  logic       full = 1'b0; // transfer covers all five bytes
  // short transfers never strobe, so latches keep their value
  always @(posedge clk) begin
    left <= read_go ? n_bytes : left - 3'(left != 3'h0);
    full <= read_go ? (n_bytes == 3'h5) : full;
    read_done <= !read_go && left == 3'h1 && full;
  end
endmodule
`default_nettype wire

// file: dv/amp_load_and_clip_diagnostics_bench.sv
/* amp_load_and_clip_diagnostics_bench: directed tests of ald_diag.
   assumes ald_host_model ends status reads; ev packs pulses and ana[0]. */
`timescale 1ns/10ps
`default_nettype none
module amp_load_and_clip_diagnostics_bench;
  logic clk, sys_rst, ac_view_sel, high_current, line_driver_sel, gain_front_16, gain_rear_16;
  logic temp_on_fault, load_on_fault, engine_start, amp_started, temp_warn, status_read_done;
  logic sup_above_10v, sup_above_7v5, sup_above_6v, fault_pin, standby_mode_pin, cm_reduced;
  logic [1:0] clip_thresh, clip_lv_mode, gain_16db;
  logic [2:0] n_bytes;
  logic [3:0] clip_to_stb;
  logic [7:0] diag_result, global_status_byte;
  logic [11:0] ev; // read, ac enable, done, start, then ana[0]
  logic [31:0] channel_status_byte;
  int fails = 0;
  int n_checks = 0;
  ald_diag u_dut (.clk, .sys_rst, .ac_enable_wr(ev[10]), .ac_view_sel, .high_current,
    .line_driver_sel, .gain_front_16, .gain_rear_16, .clip_thresh, .clip_lv_mode,
    .clip_to_stb, .temp_on_fault, .load_on_fault, .diag_start(ev[8]), .diag_done(ev[9]),
    .diag_result, .engine_start, .amp_started, .sup_above_10v, .sup_above_7v5, .sup_above_6v,
    .temp_warn, .ana({24'h0, ev[7:0]}), .status_read_done, .channel_status_byte,
    .global_status_byte, .fault_pin, .standby_mode_pin, .cm_reduced, .gain_16db);
  ald_host_model u_host (.clk, .read_go(ev[11]), .n_bytes, .read_done(status_read_done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // run should end well inside 1000 cycles
  initial begin
    #50000;
    fails++;
    end_sim();
  end
  // pulses last one cycle, clip levels in ev[2:0] stay
  task automatic go(input logic [11:0] e, input int n);
    ev = e;
    @(posedge clk) #2 ev[11:3] = 9'h0;
    repeat (n) @(posedge clk) #2;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) fails++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", s, e, g);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {sys_rst, ac_view_sel, high_current, line_driver_sel, gain_front_16, gain_rear_16} = 6'h20;
    {temp_on_fault, load_on_fault, engine_start, amp_started, temp_warn} = 5'h0;
    {sup_above_10v, sup_above_7v5, sup_above_6v, clip_thresh, clip_lv_mode, n_bytes} = 10'h0;
    {clip_to_stb, diag_result, ev} = 24'h0;
    go(12'h0, 3);
    sys_rst = 1'b0;
    chk("reset", 8'h00, global_status_byte | channel_status_byte[7:0]);
    for (int c = 0; c < 4; c++) begin
      diag_result = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
      go(12'h100, 1);
      chk("busy", 8'h20, global_status_byte);
      go(12'h200, 1);
      chk("dc code", 8'(c << 4), channel_status_byte[7:0]);
    end
    $display("dc test done");
    engine_start = 1'b1;
    go(12'h200, 1);
    chk("engine", 8'h30, channel_status_byte[7:0]);
    n_bytes = 3'h5;
    go(12'h0E0, 1); // shorts pulse once and stay latched
    chk("shorts", 8'h3B, channel_status_byte[7:0]);
    n_bytes = 3'h4;
    go(12'h810, 8);
    chk("short read", 8'h3B, channel_status_byte[7:0]);
    n_bytes = 3'h5;
    go(12'h800, 8);
    chk("cleared", 8'h34, channel_status_byte[7:0]);
    $display("latch test done");
    {ac_view_sel, amp_started, high_current} = 3'h7;
    go(12'h400, 0);
    repeat (3) go(12'h008, 1);
    chk("ac 3", 8'h00, channel_status_byte[7:0] & 8'h10);
    go(12'h008, 1);
    chk("ac 4", 8'h10, channel_status_byte[7:0] & 8'h10);
    $display("ac test done");
    for (int g = 0; g < 8; g++) begin
      {line_driver_sel, gain_rear_16, gain_front_16} = 3'(g);
      go(12'h0, 0);
      chk("cm gain", 8'({g == 7, 2'(g)}), {5'h0, cm_reduced, gain_16db});
    end
    sup_above_10v = 1'b1;
    for (int r = 0; r < 2; r++) begin
      clip_to_stb = 4'(r);
      go(12'h001, 0);
      chk("clip pins", 8'(r ? 2 : 1), {6'h0, standby_mode_pin, fault_pin});
    end
    // live short shown on fault pin only while unmasked
    load_on_fault = 1'b1;
    go(12'h081, 0);
    chk("load shown", 8'h03, {6'h0, standby_mode_pin, fault_pin});
    load_on_fault = 1'b0;
    go(12'h081, 0);
    chk("load masked", 8'h02, {6'h0, standby_mode_pin, fault_pin});
    go(12'h001, 1);
    chk("masked kept", 8'h08, channel_status_byte[7:0] & 8'h08);
    $display("pin test done");
    end_sim();
  end
endmodule
`default_nettype wire
